// File: rtl/upconverter_interp_routing.sv
`default_nettype none
module upconverter_interp_routing
  import upconverter_pkg::*;
#(
  parameter int BUFFER_DEPTH = FIFO_DEPTH
) (
  input wire logic mclk, // Sample clock
  input wire logic rst, // Synchronous reset
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write
  input wire logic [ADR_W-1:0] adr_i, // Wishbone byte address
  input wire logic [31:0] dat_i, // Wishbone write data
  input wire logic [3:0] sel_i, // Wishbone byte enables
  output logic [31:0] dat_o, // Wishbone read data
  output logic ack_o, // Wishbone acknowledge
  input wire logic [DUCS-1:0] in_valid, // Baseband pair offered, per up-converter
  output logic [DUCS-1:0] in_ready, // Baseband pair accepted
  input wire iq_t [DUCS-1:0] in_data, // Baseband pair, per up-converter
  input wire iq_t [DUCS-1:0] osc_data, // Oscillator cosine (i) and sine (q)
  output logic first_converter_valid, // First output sample valid
  input wire logic first_converter_ready, // First converter takes sample
  output logic [SAMPLE_W-1:0] first_converter_output, // First converter sample
  output logic second_converter_valid, // Second output sample valid
  input wire logic second_converter_ready, // Second converter takes sample
  output logic [SAMPLE_W-1:0] second_converter_output // Second converter sample
);
  // ==========================================================
  // State
  typedef struct packed {
    slot_t [DUCS-1:0][SLOTS-1:0] slot;
    slot_t [1:0] post;
    logic [1:0] out_valid;
    logic [1:0][SAMPLE_W-1:0] out_data;
    cfg_t cfg;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t st;
  state_t next_st;
  logic [DUCS-1:0] fifo_v;
  logic [DUCS-1:0] fifo_r;
  iq_t [DUCS-1:0] fifo_d;
  iq_t cd [DUCS][SLOTS+1];
  logic cv [DUCS][SLOTS+1];
  logic cr [DUCS][SLOTS+1];

  // ==========================================================
  // Arithmetic helpers
  function automatic logic [SAMPLE_W-1:0] sat(input logic signed [ACC_W-1:0] v);
    if (v > ACC_W'(SAT_HI)) begin
      return SAMPLE_W'(SAT_HI);
    end else if (v < ACC_W'(SAT_LO)) begin
      return SAMPLE_W'(SAT_LO);
    end
    return v[SAMPLE_W-1:0];
  endfunction : sat

  function automatic logic signed [COEF_W-1:0] coef(input kind_t k, input int n);
    case (k)
      KIND_HB1: return COEF_W'(HB1_TAPS[n]); // [R14]
      KIND_HB2: return COEF_W'(HB2_TAPS[n]);
      KIND_HB3: return COEF_W'(HB3_TAPS[n]);
      KIND_HB4: return COEF_W'(HB4_TAPS[n]);
      KIND_HB5: return COEF_W'(HB5_TAPS[n]);
      default: return '0;
    endcase
  endfunction : coef

  function automatic logic [1:0] last_phase(input kind_t k);
    return (k == KIND_TRI) ? TRI_LAST_PHASE : HB_LAST_PHASE;
  endfunction : last_phase

  // Decomposes the total factor into a first stage and a count of later halfbands
  function automatic plan_t plan_of(input logic [FACTOR_W-1:0] f);
    plan_t p;
    p = '0;
    p.ok = 1'b1;
    case (f) // [R7]
      9'h002: p.extra = 3'h0;
      9'h003: p = '{1'b1, 1'b1, 3'h0};
      9'h004: p.extra = 3'h1;
      9'h006: p = '{1'b1, 1'b1, 3'h1};
      9'h008: p.extra = 3'h2;
      9'h00c: p = '{1'b1, 1'b1, 3'h2};
      9'h010: p.extra = 3'h3;
      9'h018: p = '{1'b1, 1'b1, 3'h3};
      9'h020: p.extra = 3'h4;
      9'h030: p = '{1'b1, 1'b1, 3'h4};
      9'h040: p.extra = 3'h5;
      9'h060: p = '{1'b1, 1'b1, 3'h5};
      9'h080: p.extra = 3'h6;
      9'h0c0: p = '{1'b1, 1'b1, 3'h6};
      9'h100: p.extra = 3'h7;
      default: p.ok = 1'b0;
    endcase
    return p;
  endfunction : plan_of

  // Stage kind per cascade slot; unused slots pass straight through
  function automatic kind_t slot_kind(input plan_t p, input int s);
    int j;
    int r;
    int fives;
    j = s - 1;
    r = int'(p.extra) - 2;
    fives = (r >= 3) ? 2 : ((r == 2) ? 1 : 0);
    if (!p.ok) begin
      return KIND_OFF;
    end else if (s == 0) begin
      return p.tri_first ? KIND_TRI : KIND_HB1; // [R13]
    end else if (j >= int'(p.extra)) begin
      return KIND_OFF;
    end else if (j == 0) begin
      return KIND_HB2;
    end else if (j == 1) begin
      return KIND_HB3;
    end
    return ((j - 2) < (r - fives)) ? KIND_HB4 : KIND_HB5;
  endfunction : slot_kind

  // One output phase of a stage; the same taps serve both halves of the pair
  function automatic iq_t slot_out(input kind_t k, input slot_t s);
    logic signed [ACC_W-1:0] acc_i;
    logic signed [ACC_W-1:0] acc_q;
    logic signed [SAMPLE_W:0] sum_i;
    logic signed [SAMPLE_W:0] sum_q;
    logic signed [COEF_W-1:0] c;
    iq_t r;
    acc_i = '0;
    acc_q = '0;
    r = s.dline[HALF];
    if (k == KIND_TRI && s.ph != 2'h0) begin
      c = COEF_W'((s.ph == 2'h1) ? TRI_NEAR : TRI_FAR);
      acc_i = ACC_W'(c) * ACC_W'(s.dline[HALF].i)
            + ACC_W'(COEF_W'(TRI_NEAR + TRI_FAR) - c) * ACC_W'(s.dline[HALF-1].i);
      acc_q = ACC_W'(c) * ACC_W'(s.dline[HALF].q)
            + ACC_W'(COEF_W'(TRI_NEAR + TRI_FAR) - c) * ACC_W'(s.dline[HALF-1].q);
      r.i = sat(acc_i >>> COEF_SHIFT);
      r.q = sat(acc_q >>> COEF_SHIFT);
    end else if (k != KIND_TRI && s.ph != 2'h0) begin
      for (int n = 0; n < HALF; n++) begin
        c = coef(k, n);
        sum_i = (SAMPLE_W + 1)'(s.dline[HALF-1-n].i) + (SAMPLE_W + 1)'(s.dline[HALF+n].i);
        sum_q = (SAMPLE_W + 1)'(s.dline[HALF-1-n].q) + (SAMPLE_W + 1)'(s.dline[HALF+n].q);
        acc_i = acc_i + ACC_W'(c) * ACC_W'(sum_i);
        acc_q = acc_q + ACC_W'(c) * ACC_W'(sum_q);
      end
      r.i = sat(acc_i >>> COEF_SHIFT); // [R19]
      r.q = sat(acc_q >>> COEF_SHIFT);
    end
    return r;
  endfunction : slot_out

  function automatic logic slot_ready(input kind_t k, input slot_t s, input logic down);
    return (k == KIND_OFF) ? down : (!s.ov || (down && s.ph == last_phase(k)));
  endfunction : slot_ready

  // Each taken sample yields one output per phase, so rate grows by the stage ratio
  function automatic slot_t slot_step(input kind_t k, input slot_t s, input logic take,
                                      input iq_t din, input logic adv);
    slot_t r;
    r = s;
    if (k == KIND_OFF) begin
      r.ov = 1'b0;
    end else if (take) begin
      r.dline = {s.dline[TAPS-2:0], din}; // [R12]
      r.ov = 1'b1;
      r.ph = 2'h0;
    end else if (adv) begin
      if (s.ph == last_phase(k)) begin
        r.ov = 1'b0;
      end else begin
        r.ph = s.ph + 2'h1;
      end
    end
    return r;
  endfunction : slot_step

  function automatic iq_t mix(input iq_t x, input iq_t osc, input logic en);
    logic signed [ACC_W-1:0] re;
    logic signed [ACC_W-1:0] im;
    iq_t r;
    re = ACC_W'(x.i) * ACC_W'(osc.i) - ACC_W'(x.q) * ACC_W'(osc.q);
    im = ACC_W'(x.i) * ACC_W'(osc.q) + ACC_W'(x.q) * ACC_W'(osc.i);
    r.i = sat(re >>> MIX_SHIFT); // [R8]
    r.q = sat(im >>> MIX_SHIFT);
    return en ? r : x; // [R10]
  endfunction : mix

  // Unity mode maps mask bits onto the pair of stream one, complex mode onto real and imaginary halves
  function automatic logic [SAMPLE_W-1:0] combine(input logic [DUCS-1:0] mask, input logic onex,
                                                  input format_t fmt, input iq_t [DUCS-1:0] m);
    logic signed [ACC_W-1:0] acc;
    acc = '0;
    for (int b = 0; b < DUCS; b++) begin
      if (mask[b]) begin
        if (onex) begin
          if (b == 0) acc = acc + ACC_W'(m[0].i); // [R1]
          else if (b == 1) acc = acc + ACC_W'(m[0].q);
        end else if (fmt == FORMAT_COMPLEX) begin
          if (b < COMPLEX_PAIRS) acc = acc + ACC_W'(m[b].i); // [R3] [R4]
          else acc = acc + ACC_W'(m[b-COMPLEX_PAIRS].q);
        end else begin
          acc = acc + ACC_W'(m[b].i); // [R2]
        end
      end
    end
    return sat(acc); // [R16]
  endfunction : combine

  // ==========================================================
  // Input buffering
  for (genvar u = 0; u < DUCS; u++) begin : g_fifo
    sample_fifo #(.WIDTH($bits(iq_t)), .DEPTH(BUFFER_DEPTH)) u_fifo (
      .mclk(mclk),
      .rst(rst),
      .in_valid(in_valid[u]),
      .in_ready(in_ready[u]),
      .in_data(in_data[u]),
      .out_valid(fifo_v[u]),
      .out_ready(fifo_r[u]),
      .out_data(fifo_d[u])
    );
  end

  // ==========================================================
  // Datapath and register file
  always_comb begin
    plan_t plan;
    int max_ducs;
    int enabled;
    logic [DUCS-1:0] en;
    logic onex;
    logic all_v;
    logic fire;
    iq_t [DUCS-1:0] mixed;
    kind_t k;
    kind_t pk [2];
    logic [1:0] pv;
    logic [1:0] pr;
    logic [1:0] load;
    iq_t [1:0] pd;
    iq_t [1:0] comb_in;
    out_mode_t mode [2];
    logic [31:0] w;
    plan = plan_of(st.cfg.factor);
    onex = !plan.ok;
    max_ducs = (st.cfg.factor < FACTOR_W'(ONE_DUC_BELOW)) ? 1
             : ((st.cfg.factor < FACTOR_W'(TWO_DUC_BELOW)) ? 2 : DUCS); // [R11]
    enabled = int'(st.cfg.streams) / STREAMS_PER_DUC; // [R9]
    enabled = (enabled < max_ducs) ? enabled : max_ducs;
    en = '0;
    mixed = '0;
    all_v = 1'b1;
    next_st = st;
    mode[0] = st.cfg.mode0; // [R6]
    mode[1] = st.cfg.mode1;
    w = '0;
    fire = 1'b0;
    k = KIND_OFF;
    pk = '{KIND_OFF, KIND_OFF};
    pv = '0;
    pr = '0;
    pd = '0;
    comb_in = '0;
    load = {!st.out_valid[1] || second_converter_ready, !st.out_valid[0] || first_converter_ready};
    for (int u = 0; u < DUCS; u++) begin
      en[u] = (u < enabled);
      cv[u][0] = fifo_v[u];
      cd[u][0] = fifo_d[u];
      for (int s = 0; s < SLOTS; s++) begin
        k = slot_kind(plan, s);
        cv[u][s+1] = (k == KIND_OFF) ? cv[u][s] : st.slot[u][s].ov;
        cd[u][s+1] = (k == KIND_OFF) ? cd[u][s] : slot_out(k, st.slot[u][s]);
      end
      if (en[u]) begin
        mixed[u] = mix(cd[u][SLOTS], osc_data[u], st.cfg.osc_en && !onex);
        all_v = all_v && cv[u][SLOTS];
      end
    end
    comb_in[0] = '{combine(st.cfg.mask0, onex, st.cfg.fmt, mixed), '0}; // [R5]
    comb_in[1] = '{combine(st.cfg.mask1, onex, st.cfg.fmt, mixed), '0};
    for (int o = 0; o < 2; o++) begin
      pk[o] = (mode[o] == MODE_DUAL_EDGE_DOUBLED_MODE) ? KIND_HB5 : KIND_OFF; // [R17]
      pv[o] = (pk[o] == KIND_OFF) ? all_v : st.post[o].ov;
      pd[o] = (pk[o] == KIND_OFF) ? comb_in[o] : slot_out(pk[o], st.post[o]);
      pr[o] = slot_ready(pk[o], st.post[o], load[o]);
      if (load[o]) begin
        next_st.out_valid[o] = pv[o];
        next_st.out_data[o] = (mode[o] == MODE_DISABLED) ? '0 : pd[o].i;
      end
    end
    fire = all_v && pr[0] && pr[1];
    for (int o = 0; o < 2; o++) begin
      next_st.post[o] = slot_step(pk[o], st.post[o], fire, comb_in[o], st.post[o].ov && load[o]);
    end
    // Chains advance together, so every enabled channel stays in step
    for (int u = 0; u < DUCS; u++) begin
      cr[u][SLOTS] = fire || !en[u];
      for (int s = SLOTS - 1; s >= 0; s--) begin
        k = slot_kind(plan, s);
        cr[u][s] = slot_ready(k, st.slot[u][s], cr[u][s+1]);
        next_st.slot[u][s] = slot_step(k, st.slot[u][s], cv[u][s] && cr[u][s], cd[u][s],
                                       st.slot[u][s].ov && cr[u][s+1]);
      end
      fifo_r[u] = en[u] ? cr[u][0] : 1'b1;
    end
    // Bus slave: one registered acknowledge per request
    next_st.ack = 1'b0;
    next_st.rdata = '0;
    if (cyc_i && stb_i && !st.ack) begin
      next_st.ack = 1'b1;
      if (adr_i == REG_CONFIG) begin
        w[CFG_FACTOR_LSB +: FACTOR_W] = st.cfg.factor;
        w[CFG_STREAMS_LSB +: STREAMS_W] = st.cfg.streams;
        w[CFG_FORMAT_BIT] = st.cfg.fmt;
        w[CFG_OSC_BIT] = st.cfg.osc_en;
      end else if (adr_i == REG_ROUTE) begin
        w[ROUTE_MASK0_LSB +: DUCS] = st.cfg.mask0;
        w[ROUTE_MASK1_LSB +: DUCS] = st.cfg.mask1;
        w[ROUTE_MODE0_LSB +: MODE_W] = st.cfg.mode0;
        w[ROUTE_MODE1_LSB +: MODE_W] = st.cfg.mode1;
      end else if (adr_i == REG_STATUS) begin
        w[STAT_ENABLED_LSB +: 3] = 3'(enabled);
        w[STAT_PLAN_BIT] = plan.ok;
        w[STAT_FIFO_LSB +: DUCS] = fifo_v;
        w[STAT_OUT_LSB +: 2] = st.out_valid;
      end
      if (!we_i) begin
        next_st.rdata = w;
      end else begin
        for (int b = 0; b < 4; b++) begin
          if (sel_i[b]) w[8*b +: 8] = dat_i[8*b +: 8];
        end
        if (adr_i == REG_CONFIG) begin
          next_st.cfg.factor = w[CFG_FACTOR_LSB +: FACTOR_W];
          next_st.cfg.streams = w[CFG_STREAMS_LSB +: STREAMS_W];
          next_st.cfg.fmt = format_t'(w[CFG_FORMAT_BIT]);
          next_st.cfg.osc_en = w[CFG_OSC_BIT];
        end else if (adr_i == REG_ROUTE) begin
          next_st.cfg.mask0 = w[ROUTE_MASK0_LSB +: DUCS];
          next_st.cfg.mask1 = w[ROUTE_MASK1_LSB +: DUCS];
          next_st.cfg.mode0 = out_mode_t'(w[ROUTE_MODE0_LSB +: MODE_W]);
          next_st.cfg.mode1 = out_mode_t'(w[ROUTE_MODE1_LSB +: MODE_W]);
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
      st.cfg <= '{FACTOR_RESET, STREAMS_RESET, FORMAT_REAL, 1'b0, MASK0_RESET, MASK1_RESET,
                  MODE_NRZ, MODE_NRZ};
    end else begin
      st <= next_st;
    end
  end

  assign ack_o = st.ack;
  assign dat_o = st.rdata;
  assign first_converter_valid = st.out_valid[0];
  assign second_converter_valid = st.out_valid[1];
  assign first_converter_output = st.out_data[0];
  assign second_converter_output = st.out_data[1];
endmodule : upconverter_interp_routing
`default_nettype wire

// File: rtl/upconverter_pkg.sv
// Function
// R1 - Two streams, unity factor, mixing off: masks 0x1 and 0x2 pass streams straight.
// R2 - Real mode with mixing: one to four up-converters, factors 2x-256x, any masks.
// R3 - Single complex up-converter: masks 0x1 real and 0x4 imaginary, mixing on or off.
// R4 - Two complex up-converters with four streams: masks 0x3 and 0xC.
// R5 - Swapping the two programmed masks swaps the signals on the converters.
// R6 - The two converter output modes are independent of each other.
// R7 - Total factor selectable from 2 through 256 for in-phase and quadrature.
// R8 - Interpolated complex signal is multiplied by its oscillator sinusoid.
// R9 - Stream count sets enabled up-converters: 2, 4, 6, 8 give 1 to 4.
// R10 - Mixing bypass passes in-phase to in-phase and quadrature to quadrature unchanged.
// R11 - Factor limits channels: one below 4x, two below 8x, else four.
// R12 - Output rate equals input rate times factor, dual-edge doubler excluded.
// R13 - Interpolation is a cascade of fixed 2x or 3x stages before mixing.
// R14 - First halfband stage: center 65536, neighbours 41527, odd taps zero, scaled 2^-16.
// R15 - Composite filters target 80% passband, 0.01 dB ripple, 90 dB stopband.
// R16 - Each converter output is the sum of the mask-selected up-converter outputs.
// R17 - Dual-edge doubled mode adds one fixed 2x stage after combining.
// R18 - Software programs only supported combinations; others give undefined output.
// R19 - In-phase and quadrature share identical stages and latency, staying aligned.
`default_nettype none
package upconverter_pkg;
  // ==========================================================
  // Sizes
  localparam int SAMPLE_W = 16;
  localparam int DUCS = 4;
  localparam int COMPLEX_PAIRS = 2;
  localparam int STREAMS_PER_DUC = 2;
  localparam int SLOTS = 8;
  localparam int HALF = 15;
  localparam int TAPS = 2 * HALF;
  localparam int FIFO_DEPTH = 8;
  localparam int ADR_W = 8;
  localparam int ACC_W = 40;
  localparam int COEF_W = 18;
  localparam int COEF_SHIFT = 16;
  localparam int MIX_SHIFT = 15;
  localparam int FACTOR_W = 9;
  localparam int STREAMS_W = 4;
  localparam int MODE_W = 3;
  localparam int SAT_HI = (2 ** (SAMPLE_W - 1)) - 1;
  localparam int SAT_LO = -(2 ** (SAMPLE_W - 1));
  // ==========================================================
  // Filter taps, nearest side tap first, all on a 2^-16 scale
  localparam int HB1_TAPS [HALF] = '{41527, -13334, 7420, -4729, 3152, -2119, 1409, -914, 572,
                                      -342, 192, -100, 47, -19, 6};
  localparam int HB2_TAPS [HALF] = '{0: 40564, 1: -10764, 2: 4024, 3: -1344, 4: 336, 5: -48, default: 0}; // [R15]
  localparam int HB3_TAPS [HALF] = '{0: 38688, 1: -6848, 2: 928, default: 0};
  localparam int HB4_TAPS [HALF] = '{0: 38400, 1: -6400, 2: 768, default: 0};
  localparam int HB5_TAPS [HALF] = '{0: 36864, 1: -4096, default: 0};
  localparam int TRI_NEAR = 43691;
  localparam int TRI_FAR = 21845;
  localparam logic [1:0] HB_LAST_PHASE = 2'h1;
  localparam logic [1:0] TRI_LAST_PHASE = 2'h2;
  localparam int ONE_DUC_BELOW = 4;
  localparam int TWO_DUC_BELOW = 8;
  // ==========================================================
  // Register map
  localparam logic [ADR_W-1:0] REG_CONFIG = 8'h00;
  localparam logic [ADR_W-1:0] REG_ROUTE = 8'h04;
  localparam logic [ADR_W-1:0] REG_STATUS = 8'h08;
  localparam int CFG_FACTOR_LSB = 0;
  localparam int CFG_STREAMS_LSB = 16;
  localparam int CFG_FORMAT_BIT = 24;
  localparam int CFG_OSC_BIT = 25;
  localparam int ROUTE_MASK0_LSB = 0;
  localparam int ROUTE_MASK1_LSB = 4;
  localparam int ROUTE_MODE0_LSB = 8;
  localparam int ROUTE_MODE1_LSB = 12;
  localparam int STAT_ENABLED_LSB = 0;
  localparam int STAT_PLAN_BIT = 4;
  localparam int STAT_FIFO_LSB = 8;
  localparam int STAT_OUT_LSB = 12;
  localparam logic [FACTOR_W-1:0] FACTOR_RESET = 9'h001;
  localparam logic [STREAMS_W-1:0] STREAMS_RESET = 4'h2;
  localparam logic [DUCS-1:0] MASK0_RESET = 4'h1;
  localparam logic [DUCS-1:0] MASK1_RESET = 4'h2;
  // ==========================================================
  // Types
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] i;
    logic signed [SAMPLE_W-1:0] q;
  } iq_t;
  typedef enum logic [2:0] {KIND_OFF, KIND_HB1, KIND_HB2, KIND_HB3, KIND_HB4, KIND_HB5, KIND_TRI} kind_t;
  typedef enum logic [MODE_W-1:0] {MODE_DISABLED, MODE_NRZ, MODE_RTZ, MODE_RF, MODE_DES1X,
                                   MODE_DUAL_EDGE_DOUBLED_MODE} out_mode_t;
  typedef enum logic {FORMAT_REAL, FORMAT_COMPLEX} format_t;
  typedef struct packed {
    logic [1:0] ph;
    logic ov;
    iq_t [TAPS-1:0] dline;
  } slot_t;
  typedef struct packed {
    logic [FACTOR_W-1:0] factor;
    logic [STREAMS_W-1:0] streams;
    format_t fmt;
    logic osc_en;
    logic [DUCS-1:0] mask0;
    logic [DUCS-1:0] mask1;
    out_mode_t mode0;
    out_mode_t mode1;
  } cfg_t;
  typedef struct packed {
    logic ok;
    logic tri_first;
    logic [2:0] extra;
  } plan_t;
endpackage : upconverter_pkg
`default_nettype wire

// File: rtl/sample_fifo.sv
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic mclk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic in_valid, // Source has a word
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Drain takes the word
  output logic [WIDTH-1:0] out_data // Oldest word
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W:0] FULL = (PTR_W + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr;
    logic [PTR_W-1:0] rd;
    logic [PTR_W:0] count;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic push;
  logic pop;

  assign in_ready = (st.count != FULL);
  assign out_valid = (st.count != '0);
  assign out_data = st.mem[st.rd];

  always_comb begin
    next_st = st;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = (st.wr == LAST) ? '0 : st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = (st.rd == LAST) ? '0 : st.rd + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : sample_fifo
`default_nettype wire

// File: testbench/upconverter_interp_routing_chk.sv
`default_nettype none
module upconverter_interp_routing_chk
  import upconverter_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input wire logic cyc_i, // Cycle
  input wire logic stb_i, // Strobe
  input wire logic ack_o, // Acknowledge
  input wire logic [31:0] dat_o, // Read data
  input wire logic [DUCS-1:0] in_ready, // Lane ready
  input wire logic first_converter_valid, // First valid
  input wire logic first_converter_ready, // First ready
  input wire logic [SAMPLE_W-1:0] first_converter_output, // First sample
  input wire logic second_converter_valid, // Second valid
  input wire logic second_converter_ready, // Second ready
  input wire logic [SAMPLE_W-1:0] second_converter_output // Second sample
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Bus and output handshake
  sequence req_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence stall_s;
    first_converter_valid && !first_converter_ready;
  endsequence
  bus_ack_pulse_a: assert property (req_s |=> ack_o ##1 !ack_o) else $error("ack missing");
  ack_single_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
  idle_data_zero_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data leaks");
  first_hold_a: assert property (stall_s |=> first_converter_valid && $stable(first_converter_output))
    else $error("first sample dropped");
  second_hold_a: assert property (second_converter_valid && !second_converter_ready |=>
    second_converter_valid && $stable(second_converter_output)) else $error("second sample dropped");
  cross_stall_a: assert property (first_converter_valid && !second_converter_ready |=>
    $stable(first_converter_output)) else $error("stall not shared");
  valid_pair_a: assert property (first_converter_valid == second_converter_valid)
    else $error("outputs out of step");
  reset_quiet_a: assert property ($fell(rst) |-> !first_converter_valid && in_ready == 4'hf)
    else $error("not idle after reset");
endmodule : upconverter_interp_routing_chk
bind upconverter_interp_routing upconverter_interp_routing_chk upconverter_interp_routing_chk_inst (
  .mclk(mclk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o), .in_ready(in_ready),
  .first_converter_valid(first_converter_valid), .first_converter_ready(first_converter_ready),
  .first_converter_output(first_converter_output), .second_converter_valid(second_converter_valid),
  .second_converter_ready(second_converter_ready), .second_converter_output(second_converter_output));
`default_nettype wire

// File: testbench/baseband_source.sv
`default_nettype none
module baseband_source
  import upconverter_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input wire logic pace, // Offer new words
  input wire logic [DUCS-1:0] in_ready, // Lane ready
  output logic [DUCS-1:0] in_valid, // Lane valid
  output iq_t [DUCS-1:0] in_data // Lane word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] cnt [DUCS];
  function automatic iq_t word(input int u, input logic [13:0] n);
    word.i = {u[1:0], n};
    word.q = ~{u[1:0], n};
  endfunction : word
  // Idle lanes toggle their data so a stale word never looks valid
  always_ff @(posedge mclk) begin
    for (int u = 0; u < DUCS; u++) begin
      if (rst) begin
        in_valid[u] <= 1'b0;
        cnt[u] <= 14'h0;
        in_data[u] <= '0;
      end else if (in_valid[u] && in_ready[u]) begin
        cnt[u] <= cnt[u] + 14'h1;
        in_valid[u] <= pace;
        in_data[u] <= pace ? word(u, cnt[u] + 14'h1) : ~in_data[u];
      end else if (!in_valid[u]) begin
        in_valid[u] <= pace;
        in_data[u] <= pace ? word(u, cnt[u]) : ~in_data[u];
      end
    end
  end
endmodule : baseband_source
`default_nettype wire

// File: testbench/upconverter_interp_routing_bench.sv
`default_nettype none
module upconverter_interp_routing_bench;
  import upconverter_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, cyc, stb, we, pace, run, rdy, swap, fav, sav;
  logic [7:0] adr;
  logic [31:0] dat, rd, dout;
  logic [3:0] sel, ival, irdy;
  logic [15:0] fout, sout;
  iq_t [DUCS-1:0] idat, osc;
  int miscompares, checks_done, got, pushed;
  int factors [15] = '{2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192, 256};
  logic ack;
  upconverter_interp_routing upconverter_interp_routing_inst (.mclk(mclk), .rst(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .dat_i(dat), .sel_i(sel), .dat_o(dout), .ack_o(ack), .in_valid(ival),
    .in_ready(irdy), .in_data(idat), .osc_data(osc), .first_converter_valid(fav), .first_converter_ready(rdy),
    .first_converter_output(fout), .second_converter_valid(sav), .second_converter_ready(rdy),
    .second_converter_output(sout));
  baseband_source baseband_source_inst (.mclk(mclk), .rst(rst), .pace(pace), .in_ready(irdy), .in_valid(ival),
    .in_data(idat));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // ==========================================================
  // Checks and bus access
  task automatic check32(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check32
  function automatic logic [15:0] expect_half(input int n, input logic imag);
    expect_half = imag ? ~{2'h0, 14'(n)} : {2'h0, 14'(n)};
  endfunction : expect_half
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    rd = dout;
    {cyc, stb} <= 2'b00;
  endtask : wb
  // Stream lane 0 in unity mode, then drain so no word is in flight at a reroute
  task automatic stream(input int count);
    int n;
    run <= 1'b1;
    for (n = 0; n < 3000 && got < count; n++) @(posedge mclk);
    run <= 1'b0;
    for (n = 0; n < 300 && (got != pushed || ival[0] || fav || pace); n++) @(posedge mclk);
    if (got != pushed || got < count) miscompares++;
  endtask : stream
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge mclk) begin
    pace <= run && ($urandom % 4 != 0);
    rdy <= ($urandom % 4 != 0);
    osc <= {$urandom, $urandom, $urandom, $urandom};
    if (!rst && ival[0] && irdy[0]) pushed++;
    if (!rst && fav && rdy) begin
      check32(fout, expect_half(got, swap));
      check32(sout, expect_half(got, !swap));
      got++;
    end
  end
  initial begin
    #(4 * 40000);
    miscompares++;
    print_verdict();
  end
  // ==========================================================
  // Tests
  initial begin
    void'($urandom(88));
    {cyc, stb, we, adr, dat, sel, run, swap} = '0;
    rst = 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    wb(1'b0, REG_CONFIG, 32'h0);
    check32(rd, 32'h0002_0001);
    wb(1'b0, REG_ROUTE, 32'h0);
    check32(rd, 32'h0000_1121);
    wb(1'b0, 8'h0c, 32'h0);
    check32(rd, 32'h0);
    $display("test reset values done");
    stream(40);
    $display("test passthrough done");
    wb(1'b1, REG_ROUTE, 32'h0000_3212);
    wb(1'b0, REG_ROUTE, 32'h0);
    check32(rd, 32'h0000_3212);
    swap <= 1'b1;
    stream(got + 40);
    $display("test swapped masks done");
    // Eight streams at every factor, then 2, 4 and 6 streams at 8x; status shows the clamped count
    for (int k = 0; k < 18; k++) begin
      int f, s;
      f = k < 15 ? factors[k] : 8;
      s = k < 15 ? 8 : 2 * (k - 14);
      wb(1'b1, REG_CONFIG, 32'h0200_0000 | (s << 16) | f);
      wb(1'b0, REG_STATUS, 32'h0);
      check32(rd & 32'h1f, 32'h10 | (k >= 15 ? s / 2 : f < 4 ? 1 : f < 8 ? 2 : 4));
    end
    $display("test channel limits done");
    print_verdict();
  end
endmodule : upconverter_interp_routing_bench
`default_nettype wire
